// File: svo_video_out.sv
`include "svo_defs.svh"

module svo_video_out (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // pins from the processing core and straps, asynchronous
  input  wire svo_pkg::svo_pins_s pins,
  // video output side
  output logic [9:0]              video_word,
  output svo_pkg::svo_timing_s    timing,
  output logic                    fifo_clear_n,
  output logic                    anc_packet_active,
  output logic                    timing_reference_error,
  output logic                    parallel_word_clock_out,
  output logic                    serial_video_out,
  output logic                    flag_map_active,
  // avalon-mm slave
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest
);
  import svo_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  svo_pins_s  meta_q;
  svo_pins_s  pin_q;

  // only the second stage is read by logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      pin_q  <= '0;
    end else begin
      meta_q <= pins;
      pin_q  <= meta_q;
    end
  end

  // the synchroniser restarts empty, so the serial source waits until the
  // second stage holds a real pin value
  logic [1:0] fill_q;
  logic [1:0] fill_d;
  logic       sync_full;

  assign sync_full = fill_q == `SVO_SYNC_FILL;

  always_comb begin
    fill_d = sync_full ? fill_q : 2'(fill_q + 2'h1);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_q <= 2'h0;
    end else begin
      fill_q <= fill_d;
    end
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        req;
  svo_state_s  st_q;
  svo_state_s  st_d;

  assign req             = avs_read | avs_write;
  // one wait cycle on every access
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  always_comb begin
    ack_d   = req & ~ack_q;
    ctrl_d  = ctrl_q;
    rdata_d = rdata_q;
    if (req & ~ack_q) begin
      case (avs_address[3:2])
        `SVO_REG_CTRL: rdata_d = {24'h00_0000, ctrl_q};
        `SVO_REG_STAT: rdata_d = {16'h0000, 2'b00, pin_q.flag_map_en, st_q.src_sel,
                                  pin_q.std, 1'b0, st_q.anc_act, st_q.err, st_q.tim};
        default:       rdata_d = 32'h0000_0000;
      endcase
    end
    if (avs_write & ack_q & avs_byteenable[0] & (avs_address[3:2] == `SVO_REG_CTRL)) begin
      ctrl_d = avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q  <= `SVO_CTRL_RST;
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q  <= ctrl_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // effective controls
  // ----------------------------------------------------------------
  logic blank_eff;
  logic clip_eff;
  logic chk_eff;
  logic byp_eff;
  logic vsel_eff;

  assign blank_eff = ~(pin_q.blank_en_n & ctrl_q[`SVO_CB_BLANK]);
  assign clip_eff  = pin_q.clip_and_timing_fix_en | ctrl_q[`SVO_CB_CLIP];
  assign chk_eff   = pin_q.anc_checksum_update_en | ctrl_q[`SVO_CB_CHK];
  assign byp_eff   = pin_q.error_packet_passthrough | ctrl_q[`SVO_CB_BYP];
  // host bit takes precedence when its override is set
  assign vsel_eff  = ctrl_q[`SVO_CB_VOVR] ? ctrl_q[`SVO_CB_VSEL]
                                          : pin_q.vblank_length_select;

  // ----------------------------------------------------------------
  // stream decode
  // ----------------------------------------------------------------
  logic        stb;
  logic [9:0]  o;
  logic        is_cmp;
  logic        is_pal;
  logic        trs_hit;
  logic        trs_last;
  logic        in_trs;
  logic        anc_hit;
  logic        in_anc;
  logic [3:0]  prot;
  logic        id_err;
  logic [9:0]  vlen;

  // word data is sampled with the same latency as the word clock, so the
  // source must hold each word stable around its rising edge
  assign stb      = pin_q.word_clk & ~st_q.wclk_prev;
  assign o        = st_q.pipe[4];
  assign is_cmp   = pin_q.std[1:0] == `SVO_STD_CMP;
  assign is_pal   = pin_q.std[`SVO_STD_PAL];
  assign trs_hit  = (st_q.trs_cnt == 3'h0) & (o == `SVO_TRS_PRE)
                    & (st_q.pipe[3] == `SVO_ZERO) & (st_q.pipe[2] == `SVO_ZERO)
                    & (~is_cmp | (st_q.pipe[1] == `SVO_ZERO));
  assign trs_last = st_q.trs_cnt == 3'h1;
  assign in_trs   = trs_hit | (st_q.trs_cnt != 3'h0);
  assign anc_hit  = (st_q.anc == ANC_IDLE) & ~in_trs
                    & (is_cmp ? (o == `SVO_ADF_CMP)
                              : ((o == `SVO_ZERO) & (st_q.pipe[3] == `SVO_TRS_PRE)
                                 & (st_q.pipe[2] == `SVO_TRS_PRE)));
  assign in_anc   = anc_hit | (st_q.anc != ANC_IDLE);
  assign prot     = {o[`SVO_XYZ_V] ^ o[`SVO_XYZ_H], o[`SVO_XYZ_F] ^ o[`SVO_XYZ_H],
                     o[`SVO_XYZ_F] ^ o[`SVO_XYZ_V],
                     o[`SVO_XYZ_F] ^ o[`SVO_XYZ_V] ^ o[`SVO_XYZ_H]};
  assign id_err   = is_cmp ? (o[9] == o[8]) : (~o[9] | (o[5:2] != prot));
  assign vlen     = is_pal ? (vsel_eff ? `SVO_VB_PAL_S : `SVO_VB_PAL_L)
                           : (vsel_eff ? `SVO_VB_NTSC_S : `SVO_VB_NTSC_L);

  // ----------------------------------------------------------------
  // word path state
  // ----------------------------------------------------------------
  always_comb begin
    st_d           = st_q;
    st_d.wclk_prev = pin_q.word_clk;
    st_d.wclk_out  = pin_q.word_clk;
    // serial source is caught once after reset; a change needs a new reset
    if (~st_q.src_cap & sync_full) begin
      st_d.src_cap = 1'b1;
      st_d.src_sel = pin_q.serial_out_source_select;
    end
    st_d.shift = {1'b0, st_q.shift[9:1]};
    // the processed path is limited to one bit per system clock
    st_d.ser   = st_q.src_sel ? pin_q.serial_loop : st_q.shift[0];
    if (stb) begin
      for (int i = 4; i > 0; i--) begin
        st_d.pipe[i] = st_q.pipe[i-1];
      end
      st_d.pipe[0] = pin_q.word;
      // timing reference tracking
      if (trs_hit) begin
        st_d.trs_cnt = is_cmp ? `SVO_TRS_CMP : `SVO_TRS_CPT;
      end else if (st_q.trs_cnt != 3'h0) begin
        st_d.trs_cnt = st_q.trs_cnt - 3'h1;
      end
      st_d.wcnt  = (st_q.wcnt == `SVO_MAX_LINE) ? st_q.wcnt : 12'(st_q.wcnt + 12'h001);
      st_d.phase = ~st_q.phase;
      st_d.fifo_clr_n = 1'b1;
      if (trs_last) begin
        st_d.phase = 1'b0;
        st_d.err   = id_err;
        if (is_cmp | (o[`SVO_XYZ_H] == pin_q.strobe_placement_select)) begin
          st_d.fifo_clr_n = 1'b0;
        end
        if (is_cmp) begin
          st_d.tim.f = o[2:0];
          st_d.tim.h = 1'b1;
        end else begin
          st_d.tim.f = {2'b00, o[`SVO_XYZ_F]};
          st_d.tim.h = o[`SVO_XYZ_H];
          st_d.vbit  = o[`SVO_XYZ_V];
        end
        if (is_cmp | o[`SVO_XYZ_H]) begin
          // line end: check spacing against the previous line
          if ((st_q.llen != 12'h000) & (st_q.wcnt != st_q.llen)) begin
            st_d.err = 1'b1;
          end
          st_d.llen = st_q.wcnt;
          st_d.wcnt = 12'h000;
          st_d.line = (st_d.tim.f != st_q.tim.f) ? 10'h000 : 10'(st_q.line + 10'h001);
        end
      end else if (st_q.wcnt == `SVO_MAX_LINE) begin
        st_d.err = 1'b1;
      end
      if (is_cmp & (st_q.wcnt == `SVO_CMP_HLEN)) begin
        st_d.tim.h = 1'b0;
      end
      if (is_cmp | ~is_pal) begin
        st_d.tim.v = st_d.line < vlen;
      end else begin
        st_d.tim.v = st_d.vbit;
      end
      // ancillary packet walk
      case (st_q.anc)
        ANC_IDLE: begin
          if (anc_hit) begin
            st_d.anc      = is_cmp ? ANC_DID : ANC_HDR;
            st_d.anc_left = `SVO_HDR_CPT;
          end
        end
        ANC_HDR: begin
          st_d.anc_left = 8'(st_q.anc_left - 8'h01);
          if (st_q.anc_left == 8'h01) begin
            st_d.anc = ANC_DID;
          end
        end
        ANC_DID: begin
          st_d.sum = o[8:0];
          st_d.edh = o[7:0] == `SVO_EDH_DID;
          st_d.anc = ANC_SDID;
        end
        ANC_SDID: begin
          st_d.sum = st_q.sum + o[8:0];
          st_d.anc = ANC_DC;
        end
        ANC_DC: begin
          st_d.sum      = st_q.sum + o[8:0];
          st_d.anc_left = o[7:0];
          st_d.anc      = (o[7:0] == 8'h00) ? ANC_CS : ANC_UDW;
        end
        ANC_UDW: begin
          st_d.sum      = st_q.sum + o[8:0];
          st_d.anc_left = 8'(st_q.anc_left - 8'h01);
          if (st_q.anc_left == 8'h01) begin
            st_d.anc = ANC_CS;
          end
        end
        ANC_CS:  st_d.anc = ANC_IDLE;
        default: st_d.anc = ANC_IDLE;
      endcase
      st_d.anc_act = in_anc;
      // output word selection
      st_d.dout = o;
      if (trs_last & ~is_cmp & clip_eff) begin
        st_d.dout = {1'b1, o[8:6], prot, o[1:0]};
      end else if (in_trs) begin
        st_d.dout = o;
      end else if ((st_q.anc == ANC_CS) & chk_eff & ~(st_q.edh & byp_eff)) begin
        st_d.dout = {~st_q.sum[8], st_q.sum};
      end else if (~in_anc & blank_eff) begin
        st_d.dout = is_cmp ? (is_pal ? `SVO_BLK_PAL : `SVO_BLK_NTSC)
                           : (st_q.phase ? `SVO_BLK_Y : `SVO_BLK_C);
      end else if (~in_anc & clip_eff & ~st_q.tim.h & ~st_q.tim.v) begin
        if (is_cmp) begin
          st_d.dout = (o < `SVO_CMP_LO) ? `SVO_CMP_LO
                    : (o > `SVO_CMP_HI) ? `SVO_CMP_HI : o;
        end else if (st_q.phase) begin
          st_d.dout = (o < `SVO_CLIP_LO) ? `SVO_CLIP_LO
                    : (o > `SVO_CLIP_YHI) ? `SVO_CLIP_YHI : o;
        end else begin
          st_d.dout = (o < `SVO_CLIP_LO) ? `SVO_CLIP_LO
                    : (o > `SVO_CLIP_CHI) ? `SVO_CLIP_CHI : o;
        end
      end
      st_d.shift = st_d.dout;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      // idle high, so no clear pulse follows the release of reset
      st_q.fifo_clr_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign video_word              = st_q.dout;
  assign timing                  = st_q.tim;
  assign fifo_clear_n            = ~rst & st_q.fifo_clr_n;
  assign anc_packet_active       = st_q.anc_act;
  assign timing_reference_error  = st_q.err;
  assign parallel_word_clock_out = st_q.wclk_out;
  assign serial_video_out        = st_q.ser;
  assign flag_map_active         = pin_q.flag_map_en;

endmodule : svo_video_out

// File: svo_defs.svh
`ifndef SVO_DEFS_SVH
`define SVO_DEFS_SVH

// ----------------------------------------------------------------
// stream words
// ----------------------------------------------------------------
`define SVO_TRS_PRE   10'h3ff
`define SVO_ZERO      10'h000
`define SVO_ADF_CMP   10'h3fc
`define SVO_EDH_DID   8'hf4
`define SVO_BLK_Y     10'h040
`define SVO_BLK_C     10'h200
`define SVO_BLK_NTSC  10'h0f0
`define SVO_BLK_PAL   10'h100
`define SVO_CLIP_LO   10'h040
`define SVO_CLIP_YHI  10'h3ac
`define SVO_CLIP_CHI  10'h3c0
`define SVO_CMP_LO    10'h004
`define SVO_CMP_HI    10'h3fb
`define SVO_STD_CMP   2'h1
`define SVO_STD_PAL   2
`define SVO_XYZ_F     8
`define SVO_XYZ_V     7
`define SVO_XYZ_H     6
`define SVO_TRS_CMP   3'h4
`define SVO_TRS_CPT   3'h3
`define SVO_HDR_CPT   8'h02
// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SVO_VB_NTSC_L 10'h013
`define SVO_VB_NTSC_S 10'h009
`define SVO_VB_PAL_L  10'h011
`define SVO_VB_PAL_S  10'h007
`define SVO_MAX_LINE  12'hfff
`define SVO_CMP_HLEN  12'h07f
`define SVO_SYNC_FILL 2'h2
// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
`define SVO_REG_CTRL  2'h0
`define SVO_REG_STAT  2'h1
`define SVO_CTRL_RST  8'h01
`define SVO_CB_BLANK  0
`define SVO_CB_CLIP   1
`define SVO_CB_CHK    2
`define SVO_CB_BYP    3
`define SVO_CB_VSEL   4
`define SVO_CB_VOVR   5
`endif

// File: svo_pkg.sv
package svo_pkg;
  typedef struct packed {
    logic       word_clk;
    logic [9:0] word;
    logic       serial_loop;
    logic [3:0] std;
    logic       strobe_placement_select;
    logic       flag_map_en;
    logic       vblank_length_select;
    logic       error_packet_passthrough;
    logic       serial_out_source_select;
    logic       blank_en_n;
    logic       anc_checksum_update_en;
    logic       clip_and_timing_fix_en;
  } svo_pins_s;

  typedef struct packed {
    logic [2:0] f;
    logic       v;
    logic       h;
  } svo_timing_s;

  typedef enum logic [2:0] {
    ANC_IDLE, ANC_HDR, ANC_DID, ANC_SDID, ANC_DC, ANC_UDW, ANC_CS
  } svo_anc_e;

  typedef struct packed {
    logic [4:0][9:0] pipe;
    logic [2:0]      trs_cnt;
    svo_anc_e        anc;
    logic [7:0]      anc_left;
    logic            edh;
    logic [8:0]      sum;
    logic            phase;
    logic            vbit;
    logic [9:0]      line;
    logic [11:0]     wcnt;
    logic [11:0]     llen;
    logic [9:0]      dout;
    svo_timing_s     tim;
    logic            fifo_clr_n;
    logic            anc_act;
    logic            err;
    logic            wclk_prev;
    logic            wclk_out;
    logic            src_cap;
    logic            src_sel;
    logic [9:0]      shift;
    logic            ser;
  } svo_state_s;
endpackage : svo_pkg

// File: svo_video_out_properties.sv
module svo_video_out_properties (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // watched ports
  input wire svo_pkg::svo_pins_s   pins,
  input wire logic [9:0]           video_word,
  input wire svo_pkg::svo_timing_s timing,
  input wire logic                 fifo_clear_n,
  input wire logic                 anc_packet_active,
  input wire logic                 timing_reference_error,
  input wire logic                 parallel_word_clock_out,
  input wire logic                 flag_map_active,
  input wire logic [3:0]           avs_address,
  input wire logic                 avs_read,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  import svo_pkg::*;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  // counts assume a word period of 9 to 10 clocks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_clr_one_word;
    $fell(fifo_clear_n) |=> !fifo_clear_n [*8] ##[1:3] fifo_clear_n;
  endproperty
  a_clr_one_word: assert property (p_clr_one_word) else $error("clear width");
  property p_clr_on_trs;
    $fell(fifo_clear_n) |-> video_word == 10'h3ff || video_word == 10'h000 || video_word[9];
  endproperty
  a_clr_on_trs: assert property (p_clr_on_trs) else $error("clear off trs");
  property p_word_hold;
    $changed(video_word) |=> $stable(video_word) [*7];
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word too short");
  property p_tim_hold;
    $changed(timing) |=> $stable(timing) [*7];
  endproperty
  a_tim_hold: assert property (p_tim_hold) else $error("timing too short");
  property p_anc_span;
    $rose(anc_packet_active) |=> anc_packet_active [*8];
  endproperty
  a_anc_span: assert property (p_anc_span) else $error("anc too short");
  property p_err_hold;
    $rose(timing_reference_error) |=> timing_reference_error [*6];
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error glitch");
  property p_flag_map;
    $stable(pins.flag_map_en) [*5] |-> flag_map_active == pins.flag_map_en;
  endproperty
  a_flag_map: assert property (p_flag_map) else $error("flag map stale");
  property p_pclk;
    $stable(pins.word_clk) [*4] |-> parallel_word_clock_out == pins.word_clk;
  endproperty
  a_pclk: assert property (p_pclk) else $error("word clock out stale");
  property p_unmapped;
    avs_read && avs_address[3] && !avs_waitrequest |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_reset_quiet;
    disable iff (1'b0) rst && $past(rst) |->
      !fifo_clear_n && video_word == 10'h000 && !anc_packet_active;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset leak");
endmodule : svo_video_out_properties

bind svo_video_out svo_video_out_properties u_props (.*);

// File: svo_sink_model.sv
module svo_sink_model (
  // watched outputs
  input wire logic                 pclk,
  input wire logic [9:0]           word,
  input wire svo_pkg::svo_timing_s tim,
  input wire logic                 fifo_n,
  input wire logic                 anc,
  input wire logic                 err
);
  timeunit 1ns;
  timeprecision 1ps;
  import svo_pkg::*;
  typedef struct packed {
    logic [9:0] w;
    logic [2:0] f;
    logic       fn;
    logic       an;
  } svo_cap_s;
  svo_cap_s q[$];
  logic     es = 1'b0;
  // sample mid-word, far from the update edge
  always @(negedge pclk) q.push_back('{word, tim.f, fifo_n, anc});
  always @(posedge err) es = 1'b1;
endmodule : svo_sink_model

// File: tb_svo_video_out.sv
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH %0t %h %h", $time, (a), (b)); end end

module tb_svo_video_out;
  timeunit 1ns;
  timeprecision 1ps;
  import svo_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic       pl;
    logic       bn;
    logic       cl;
    logic       ck;
    logic       f;
  } svo_row_s;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  svo_pins_s   pins;
  logic [9:0]  video_word;
  svo_timing_s timing;
  logic        fifo_clear_n, anc_packet_active, timing_reference_error;
  logic        parallel_word_clock_out, serial_video_out, flag_map_active;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest;
  logic [9:0]  ln [24];
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;
  svo_row_s    rows [9] = '{'{8'h01, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
    '{8'h01, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1}, '{8'h01, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
    '{8'h00, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0}, '{8'h01, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},
    '{8'h03, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1}, '{8'h01, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0},
    '{8'h05, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0}, '{8'h0d, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0}};
  int          n_low = 0;

  svo_video_out dut (.*);
  svo_sink_model u_sink (.pclk(parallel_word_clock_out), .word(video_word), .tim(timing),
    .fifo_n(fifo_clear_n), .anc(anc_packet_active), .err(timing_reference_error));

  // ----------------------------------------
  // clocks and helpers
  // ----------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end
  // word clock edges never land on a rising clk edge
  initial begin
    pins = '0;
    pins.blank_en_n = 1'b1;
    pins.serial_out_source_select = 1'b1;
    forever #24 pins.word_clk = ~pins.word_clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out();
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    // the answer is taken at the rising edge that sees waitrequest low
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  function automatic void mk(input logic f);
    ln = '{10'h3ff, 10'h000, 10'h000, f ? 10'h368 : 10'h274,
      10'h000, 10'h3ff, 10'h3ff, 10'h250, 10'h101, 10'h101, 10'h123, 10'h2aa, 10'h200,
      10'h040, 10'h3ff, 10'h000, 10'h000, f ? 10'h31c : 10'h200,
      10'h200, 10'h3f0, 10'h200, 10'h010, 10'h200, 10'h1a0};
  endfunction : mk

  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge pins.word_clk);
      @(posedge clk);
      pins.word <= ln[i];
    end
  endtask : send

  task automatic row(input svo_row_s r);
    int         j;
    int         lows;
    logic       bl, cl, ck;
    logic [9:0] e;
    bl = !(r.bn & r.ctrl[0]);
    cl = r.cl | r.ctrl[1];
    ck = r.ck | r.ctrl[2];
    bus(1'b1, 4'h0, {24'h00_0000, r.ctrl});
    pins.strobe_placement_select <= r.pl;
    pins.blank_en_n <= r.bn;
    pins.clip_and_timing_fix_en <= r.cl;
    pins.anc_checksum_update_en <= r.ck;
    mk(r.f);
    if (r.ctrl[3]) ln[7] = 10'h2f4;
    // clipping only acts past the 19 blanking lines of the field
    if (cl) repeat (19) send(24);
    send(24);
    u_sink.q.delete();
    send(24);
    send(24);
    j = -1;
    lows = 0;
    for (int k = 12; k >= 0; k--) begin
      if (u_sink.q[k].w === 10'h3ff && u_sink.q[k + 3].w === ln[3]) j = k;
    end
    `CHK(j >= 0, 1'b1)
    if (j < 0) j = 0;
    for (int i = 0; i < 24; i++) begin
      e = ln[i];
      if (i >= 18 && bl) e = i[0] ? 10'h040 : 10'h200;
      else if (i >= 18 && cl && e == 10'h3f0) e = 10'h3ac;
      else if (i >= 18 && cl && e == 10'h010) e = 10'h040;
      if (i == 11 && ck && !r.ctrl[3]) e = 10'h175;
      `CHK(u_sink.q[j + i].w, e)
      `CHK(u_sink.q[j + i].an, i >= 4 && i < 12)
      if (i >= 18) `CHK(u_sink.q[j + i].f, {2'b00, r.f})
      if (u_sink.q[j + i].fn === 1'b0) begin
        lows++;
        `CHK(r.pl ? i < 4 : i >= 14 && i < 18, 1'b1)
      end
    end
    `CHK(lows, 1)
  endtask : row

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, 4'h4, 32'h0000_0000);
    `CHK(rd[12], 1'b1)
    pins.serial_loop <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(serial_video_out, 1'b1)
    pins.serial_loop <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(serial_video_out, 1'b0)
    // the source is taken once, so the change is followed by a reset
    pins.serial_out_source_select <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(fifo_clear_n, 1'b0)
    `CHK(video_word, 10'h000)
    rst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    bus(1'b1, 4'h8, 32'h0000_0000);
    bus(1'b0, 4'h8, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    bus(1'b0, 4'h0, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    foreach (rows[n]) row(rows[n]);
    pins.flag_map_en <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(flag_map_active, 1'b1)
    bus(1'b0, 4'h4, 32'h0000_0000);
    `CHK(rd[13], 1'b1)
    `CHK(rd[12], 1'b0)
    u_sink.es = 1'b0;
    mk(1'b0);
    send(20);
    repeat (3) send(24);
    `CHK(u_sink.es, 1'b1)
    repeat (2) send(24);
    `CHK(timing_reference_error, 1'b0)
    // composite: five-word timing reference ending in the id word
    pins.std <= 4'h1;
    ln[3] = 10'h000;
    ln[4] = 10'h205;
    send(24);
    u_sink.q.delete();
    repeat (2) send(24);
    foreach (u_sink.q[k]) begin
      if (u_sink.q[k].fn === 1'b0) begin
        n_low++;
        `CHK(u_sink.q[k].w, 10'h205)
        `CHK(u_sink.q[k].f, 3'h5)
      end
    end
    `CHK(n_low, 2)
    close_out();
  end
endmodule : tb_svo_video_out
